/* File: rac_api_block.sv */
// api frame handling: transmit options, loopback and remote commands
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] option bit 0 turns off acknowledgments for unicasts of the request
// [R2] option bit 1 skips route discovery, mesh unicasts only
// [R3] option bit 2 plus failed mesh unicast yields route information frame 0x8d
// [R4] option bit 3 on mesh unicast yields trace route information frame
// [R5] host keeps unused option bits, reserved bit 5 included, at zero
// [R6] option bits combine freely, each applied on its own
// [R7] bits 7:6 pick ptmp, repeater or mesh; mesh needs delivery setting nonzero
// [R8] bits 7:6 zero pick ptmp if delivery setting zero, else mesh
// [R9] zero options byte means use stored default transmit options
// [R10] loopback cluster 0x0012 is echoed back, no receive frame at destination
// [R11] returned loopback packet gives receive frame typed by output format
// [R12] every explicit request gets status frame 0x8b with its frame id
// [R13] frame 0x17 is a remote parameter request answered by frame 0x97
// [R14] remote writes stay pending until apply bit or apply command
// [R15] command characters followed straight by checksum mean a read query
// [R16] query answers carry the value currently in effect
// [R17] response carries the request's frame id
// [R18] host should send remote commands as unicasts only
// [R19] broadcast remote commands are answered at once by every node
// [R20] checksum is 0xff minus low byte of sum from type on
// [R21] frame id zero suppresses the response frame
// [R22] remote option bit 1 applies the change at once
// [R23] frames failing the checksum are dropped without any action; here they still bump the saturating bad frame counter bad_cnt
module rac_api_block import rac_pkg::*; #(
	parameter int NPARAM = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] host_byte,
	input wire logic host_valid,
	input wire logic host_last,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_done,
	input wire logic tx_ok,
	output rac_tx_t tx_req,
	input wire rac_netrx_t net_rx,
	output logic loop_echo,
	output rac_rcmd_t rcmd_out,
	input wire rac_rrep_t rrep_in,
	input wire rac_rcmd_t rcmd_in,
	output rac_rrep_t rrep_out,
	output rac_resp_t resp
);
	logic [7:0] idx;
	logic good;
	logic bad;

	rac_frame_check u_check (
		.core_clk(core_clk),
		.reset(reset),
		.in_byte(host_byte),
		.in_valid(host_valid),
		.in_last(host_last),
		.idx(idx),
		.good(good),
		.bad(bad)
	);

	rac_param_store #(.NPARAM(NPARAM)) u_store (
		.core_clk(core_clk),
		.reset(reset),
		.cmd(rcmd_in),
		.rep(rrep_out)
	);

	// fields caught from the host frame
	logic [7:0] f_type;
	logic [7:0] f_id;
	logic [7:0] f_opt;
	logic [15:0] f_clu;
	logic [7:0] f_rcopt;
	logic [15:0] f_cmd;
	logic [15:0] f_par;
	logic [7:0] next_f_type;
	logic [7:0] next_f_id;
	logic [7:0] next_f_opt;
	logic [15:0] next_f_clu;
	logic [7:0] next_f_rcopt;
	logic [15:0] next_f_cmd;
	logic [15:0] next_f_par;

	always_comb begin
		next_f_type = f_type;
		next_f_id = f_id;
		next_f_opt = f_opt;
		next_f_clu = f_clu;
		next_f_rcopt = f_rcopt;
		next_f_cmd = f_cmd;
		next_f_par = f_par;
		if (host_valid && !host_last) begin
			if (idx == 8'h00)
				next_f_type = host_byte;
			if (idx == IDX_FRAME_ID)
				next_f_id = host_byte;
			if (idx == IDX_TX_OPT)
				next_f_opt = host_byte;
			if (idx == IDX_CLU_HI)
				next_f_clu[15:8] = host_byte;
			if (idx == IDX_CLU_LO)
				next_f_clu[7:0] = host_byte;
			if (idx == IDX_RC_OPT)
				next_f_rcopt = host_byte;
			if (idx == IDX_CMD_HI)
				next_f_cmd[15:8] = host_byte;
			if (idx == IDX_CMD_LO)
				next_f_cmd[7:0] = host_byte;
			if (idx == IDX_PAR_HI)
				next_f_par[15:8] = host_byte;
			if (idx == IDX_PAR_LO)
				next_f_par[7:0] = host_byte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			f_type <= 8'h00;
			f_id <= 8'h00;
			f_opt <= 8'h00;
			f_clu <= 16'h0000;
			f_rcopt <= 8'h00;
			f_cmd <= 16'h0000;
			f_par <= 16'h0000;
		end else begin
			f_type <= next_f_type;
			f_id <= next_f_id;
			f_opt <= next_f_opt;
			f_clu <= next_f_clu;
			f_rcopt <= next_f_rcopt;
			f_cmd <= next_f_cmd;
			f_par <= next_f_par;
		end
	end

	// effective options of an explicit transmit request
	function automatic rac_tx_t decode_tx(input logic [7:0] raw, input logic [7:0] dflt,
		input logic mesh_ok, input logic [7:0] id, input logic [15:0] clu);
		logic [7:0] o;
		rac_tx_t t;
		logic mesh;
		o = (raw == 8'h00) ? dflt : raw; // [R9]
		t = '0;
		t.valid = 1'b1;
		t.frame_id = id;
		case (o[7:6])
			DM_PTMP: t.method = DM_PTMP; // [R7]
			DM_REPEATER: t.method = DM_REPEATER;
			// mesh request falls back to ptmp when mesh is off
			DM_MESH: t.method = mesh_ok ? DM_MESH : DM_PTMP; // [R7]
			default: t.method = mesh_ok ? DM_MESH : DM_PTMP; // [R8]
		endcase
		mesh = (t.method == DM_MESH);
		// reserved bits are trusted zero and simply ignored [R5]
		t.ack_off = o[TXO_ACK_OFF]; // [R1] [R6]
		t.route_skip = mesh && o[TXO_NO_ROUTE]; // [R2]
		t.fail_notice = mesh && o[TXO_FAIL_NOTE]; // [R3]
		t.trace = mesh && o[TXO_TRACE]; // [R4]
		t.loopback = (clu == LOOPBACK_CLUSTER);
		return t;
	endfunction

	logic [7:0] cfg_txo;
	logic [7:0] cfg_deliv;
	logic [7:0] cfg_api;
	logic [3:0] bad_cnt;
	logic [7:0] tx_id;
	logic tx_note;
	logic tx_trace;
	logic p_stat;
	logic p_route;
	logic p_rc;
	logic p_rx;
	logic [7:0] stat_id;
	logic stat_ok;
	logic [7:0] rc_id;
	logic [15:0] rc_val;
	logic [7:0] rx_type;
	logic [7:0] next_cfg_txo;
	logic [7:0] next_cfg_deliv;
	logic [7:0] next_cfg_api;
	logic [3:0] next_bad_cnt;
	logic [7:0] next_tx_id;
	logic next_tx_note;
	logic next_tx_trace;
	logic next_p_stat;
	logic next_p_route;
	logic next_p_rc;
	logic next_p_rx;
	logic [7:0] next_stat_id;
	logic next_stat_ok;
	logic [7:0] next_rc_id;
	logic [15:0] next_rc_val;
	logic [7:0] next_rx_type;
	logic [7:0] next_reg_rdata;
	rac_tx_t next_tx_req;
	rac_rcmd_t next_rcmd_out;
	logic next_loop_echo;
	rac_resp_t next_resp;
	logic set_stat;
	logic set_route;
	logic set_rc;
	logic set_rx;
	logic is_loop;

	always_comb begin
		next_cfg_txo = cfg_txo;
		next_cfg_deliv = cfg_deliv;
		next_cfg_api = cfg_api;
		next_bad_cnt = bad_cnt;
		next_tx_id = tx_id;
		next_tx_note = tx_note;
		next_tx_trace = tx_trace;
		next_stat_id = stat_id;
		next_stat_ok = stat_ok;
		next_rc_id = rc_id;
		next_rc_val = rc_val;
		next_rx_type = rx_type;
		next_tx_req = '0;
		next_rcmd_out = '0;
		next_resp = '0;
		next_reg_rdata = 8'h00;
		if (reg_wr) begin
			if (reg_addr == REG_DEF_TXO)
				next_cfg_txo = reg_wdata;
			if (reg_addr == REG_DELIVERY)
				next_cfg_deliv = reg_wdata;
			if (reg_addr == REG_API_FMT)
				next_cfg_api = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				REG_DEF_TXO: next_reg_rdata = cfg_txo;
				REG_DELIVERY: next_reg_rdata = cfg_deliv;
				REG_API_FMT: next_reg_rdata = cfg_api;
				REG_STATUS: next_reg_rdata = {bad_cnt, p_rx, p_rc, p_route, p_stat};
				default: next_reg_rdata = 8'h00;
			endcase
		end
		// a bad frame only bumps the counter [R23]
		if (bad && bad_cnt != 4'hf)
			next_bad_cnt = 4'(bad_cnt + 4'h1);
		if (good && f_type == FT_TX_EXPL) begin
			next_tx_req = decode_tx(f_opt, cfg_txo, cfg_deliv != 8'h00, f_id, f_clu);
			next_tx_id = f_id;
			next_tx_note = next_tx_req.fail_notice;
			next_tx_trace = next_tx_req.trace;
		end
		if (good && f_type == FT_RCMD) begin
			next_rcmd_out.valid = 1'b1; // [R13]
			next_rcmd_out.frame_id = f_id;
			next_rcmd_out.cmd = f_cmd;
			next_rcmd_out.query = (idx == RC_QUERY_IDX); // [R15]
			next_rcmd_out.apply = f_rcopt[RCO_APPLY]; // [R22]
			next_rcmd_out.value = f_par;
		end
		// one status per request, none for id zero [R12] [R21]
		set_stat = tx_done && tx_id != 8'h00;
		// route frame answers the request too, so id zero silences it [R21]
		set_route = tx_done && tx_id != 8'h00 && ((tx_note && !tx_ok) || tx_trace); // [R3] [R4]
		if (set_stat) begin
			next_stat_id = tx_id;
			next_stat_ok = tx_ok;
		end
		set_rc = rrep_in.valid && rrep_in.frame_id != 8'h00; // [R13] [R21]
		if (set_rc) begin
			next_rc_id = rrep_in.frame_id; // [R17]
			next_rc_val = rrep_in.value;
		end
		is_loop = net_rx.cluster == LOOPBACK_CLUSTER && !net_rx.looped;
		next_loop_echo = net_rx.valid && is_loop; // [R10]
		set_rx = net_rx.valid && !is_loop;
		if (set_rx)
			next_rx_type = (cfg_api == 8'h00) ? FT_RX_NATIVE : FT_RX_EXPL; // [R11]
		// one frame per cycle to the host, status first
		if (p_stat)
			next_resp = '{1'b1, FT_TX_STAT, stat_id, {15'h0, !stat_ok}};
		else if (p_route)
			next_resp = '{1'b1, FT_ROUTE, tx_id, {15'h0, tx_trace}};
		else if (p_rc)
			next_resp = '{1'b1, FT_RCMD_RESP, rc_id, rc_val};
		else if (p_rx)
			next_resp = '{1'b1, rx_type, 8'h00, 16'h0000};
		// a new event beats the clear of its own flag
		next_p_stat = set_stat || (p_stat && 1'b0);
		next_p_route = set_route || (p_route && p_stat);
		next_p_rc = set_rc || (p_rc && (p_stat || p_route));
		next_p_rx = set_rx || (p_rx && (p_stat || p_route || p_rc));
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_txo <= DEF_TXO_RST;
			cfg_deliv <= DELIVERY_RST;
			cfg_api <= API_FMT_RST;
			bad_cnt <= 4'h0;
			tx_id <= 8'h00;
			tx_note <= 1'b0;
			tx_trace <= 1'b0;
			p_stat <= 1'b0;
			p_route <= 1'b0;
			p_rc <= 1'b0;
			p_rx <= 1'b0;
			stat_id <= 8'h00;
			stat_ok <= 1'b0;
			rc_id <= 8'h00;
			rc_val <= 16'h0000;
			rx_type <= 8'h00;
			reg_rdata <= 8'h00;
			tx_req <= '0;
			rcmd_out <= '0;
			loop_echo <= 1'b0;
			resp <= '0;
		end else begin
			cfg_txo <= next_cfg_txo;
			cfg_deliv <= next_cfg_deliv;
			cfg_api <= next_cfg_api;
			bad_cnt <= next_bad_cnt;
			tx_id <= next_tx_id;
			tx_note <= next_tx_note;
			tx_trace <= next_tx_trace;
			p_stat <= next_p_stat;
			p_route <= next_p_route;
			p_rc <= next_p_rc;
			p_rx <= next_p_rx;
			stat_id <= next_stat_id;
			stat_ok <= next_stat_ok;
			rc_id <= next_rc_id;
			rc_val <= next_rc_val;
			rx_type <= next_rx_type;
			reg_rdata <= next_reg_rdata;
			tx_req <= next_tx_req;
			rcmd_out <= next_rcmd_out;
			loop_echo <= next_loop_echo;
			resp <= next_resp;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_status_sent: assert property (p_stat |=> resp.valid && resp.frame_type == FT_TX_STAT
		&& resp.frame_id == $past(stat_id)) // [R12]
		else $error("transmit status not sent");
	chk_id_zero_quiet: assert property (tx_done && tx_id == 8'h00 |=> !p_stat) // [R21]
		else $error("status raised for frame id zero");
	chk_bad_dropped: assert property (bad |=> !tx_req.valid && !rcmd_out.valid) // [R23]
		else $error("bad frame acted upon");
	chk_default_opts: assert property (good && f_type == FT_TX_EXPL && f_opt == 8'h00
		|=> tx_req.ack_off == $past(cfg_txo[TXO_ACK_OFF])) // [R9]
		else $error("default transmit options not used");
	chk_mesh_only: assert property (tx_req.valid && tx_req.method != DM_MESH
		|-> !tx_req.route_skip && !tx_req.fail_notice && !tx_req.trace) // [R2]
		else $error("mesh option on non-mesh delivery");
	chk_mesh_gate: assert property (tx_req.valid && $past(cfg_deliv) == 8'h00
		|-> tx_req.method != DM_MESH) // [R7]
		else $error("mesh chosen with delivery setting zero");
	chk_loop_echo: assert property (net_rx.valid && is_loop |=> loop_echo ##1 !p_rx) // [R10]
		else $error("loopback packet not echoed");
	chk_route_note: assert property (tx_done && tx_note && !tx_ok && tx_id != 8'h00
		|-> ##[1:3] resp.valid && resp.frame_type == FT_ROUTE) // [R3]
		else $error("route information frame missing");
	chk_query_seen: assert property (good && f_type == FT_RCMD && idx == RC_QUERY_IDX
		|=> rcmd_out.valid && rcmd_out.query) // [R15]
		else $error("query not detected");
	chk_rc_id: assert property (set_rc |=> p_rc && rc_id == $past(rrep_in.frame_id)) // [R17]
		else $error("remote response id lost");

	cov_loopback: cover property (tx_req.valid && tx_req.loopback);
	cov_route: cover property (resp.valid && resp.frame_type == FT_ROUTE);
	cov_query: cover property (rcmd_out.valid && rcmd_out.query);
	cov_bad: cover property (bad);
endmodule
`default_nettype wire

/* File: rac_pkg.sv */
// shared constants and types for the radio api option and remote command block
package rac_pkg;
	localparam logic [7:0] FT_TX_EXPL = 8'h11;
	localparam logic [7:0] FT_RCMD = 8'h17;
	localparam logic [7:0] FT_TX_STAT = 8'h8b;
	localparam logic [7:0] FT_ROUTE = 8'h8d;
	localparam logic [7:0] FT_RCMD_RESP = 8'h97;
	localparam logic [7:0] FT_RX_NATIVE = 8'h90;
	localparam logic [7:0] FT_RX_EXPL = 8'h91;
	localparam logic [7:0] CSUM_OK = 8'hff;
	localparam logic [15:0] LOOPBACK_CLUSTER = 16'h0012;
	localparam logic [15:0] APPLY_CMD = 16'h4143;
	localparam int TXO_ACK_OFF = 0;
	localparam int TXO_NO_ROUTE = 1;
	localparam int TXO_FAIL_NOTE = 2;
	localparam int TXO_TRACE = 3;
	localparam int RCO_APPLY = 1;
	localparam logic [7:0] IDX_FRAME_ID = 8'h01;
	localparam logic [7:0] IDX_RC_OPT = 8'h0c;
	localparam logic [7:0] IDX_CMD_HI = 8'h0d;
	localparam logic [7:0] IDX_CMD_LO = 8'h0e;
	localparam logic [7:0] IDX_CLU_HI = 8'h0e;
	localparam logic [7:0] IDX_CLU_LO = 8'h0f;
	localparam logic [7:0] IDX_PAR_HI = 8'h0f;
	localparam logic [7:0] IDX_PAR_LO = 8'h10;
	localparam logic [7:0] IDX_TX_OPT = 8'h13;
	localparam logic [7:0] RC_QUERY_IDX = 8'h0f;
	localparam logic [3:0] REG_DEF_TXO = 4'h0;
	localparam logic [3:0] REG_DELIVERY = 4'h4;
	localparam logic [3:0] REG_API_FMT = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam logic [7:0] DEF_TXO_RST = 8'h00;
	localparam logic [7:0] DELIVERY_RST = 8'h00;
	localparam logic [7:0] API_FMT_RST = 8'h00;
	typedef enum logic [1:0] {
		DM_DEFAULT = 2'b00,
		DM_PTMP = 2'b01,
		DM_REPEATER = 2'b10,
		DM_MESH = 2'b11
	} rac_method_t;
	typedef struct packed {
		logic valid;
		logic [7:0] frame_id;
		logic ack_off;
		logic route_skip;
		logic fail_notice;
		logic trace;
		rac_method_t method;
		logic loopback;
	} rac_tx_t;
	typedef struct packed {
		logic valid;
		logic [7:0] frame_id;
		logic [15:0] cmd;
		logic query;
		logic apply;
		logic [15:0] value;
	} rac_rcmd_t;
	typedef struct packed {
		logic valid;
		logic [7:0] frame_id;
		logic [15:0] value;
	} rac_rrep_t;
	typedef struct packed {
		logic valid;
		logic [15:0] cluster;
		logic looped;
	} rac_netrx_t;
	typedef struct packed {
		logic valid;
		logic [7:0] frame_type;
		logic [7:0] frame_id;
		logic [15:0] status;
	} rac_resp_t;
endpackage

/* File: rac_frame_check.sv */
// byte position counter and frame checksum check
`timescale 1ns/1ps
`default_nettype none
module rac_frame_check import rac_pkg::*; (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [7:0] in_byte,
	input wire logic in_valid,
	input wire logic in_last,
	output logic [7:0] idx,
	output logic good,
	output logic bad
);
	logic [7:0] sum;
	logic [7:0] next_sum;
	logic [7:0] next_idx;
	logic [7:0] total;

	always_comb begin
		total = 8'(sum + in_byte);
		next_sum = sum;
		next_idx = idx;
		if (in_valid) begin
			next_sum = in_last ? 8'h00 : total;
			next_idx = in_last ? 8'h00 : ((idx == 8'hff) ? idx : 8'(idx + 8'h01));
		end
		// whole sum including checksum byte lands on 0xff [R20]
		good = in_valid && in_last && (total == CSUM_OK);
		bad = in_valid && in_last && (total != CSUM_OK);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sum <= 8'h00;
			idx <= 8'h00;
		end else begin
			sum <= next_sum;
			idx <= next_idx;
		end
	end

	chk_sum_restart: assert property (@(posedge core_clk) disable iff (reset)
		in_valid && in_last |=> sum == 8'h00 && idx == 8'h00) // [R20]
		else $error("checksum state not cleared after frame end");
endmodule
`default_nettype wire

/* File: rac_param_store.sv */
// parameter table of the remote node with pending and active copies
`timescale 1ns/1ps
`default_nettype none
module rac_param_store import rac_pkg::*; #(
	parameter int NPARAM = 8,
	parameter int IW = $clog2(NPARAM)
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire rac_rcmd_t cmd,
	output rac_rrep_t rep
);
	logic [15:0] active [NPARAM];
	logic [15:0] pending [NPARAM];
	logic [NPARAM-1:0] pend;
	logic [15:0] next_active [NPARAM];
	logic [15:0] next_pending [NPARAM];
	logic [NPARAM-1:0] next_pend;
	rac_rrep_t next_rep;
	logic [IW-1:0] sel;
	logic is_apply_cmd;
	logic apply;

	always_comb begin
		sel = cmd.cmd[IW-1:0];
		is_apply_cmd = (cmd.cmd == APPLY_CMD);
		apply = cmd.apply || is_apply_cmd;
		next_active = active;
		next_pending = pending;
		next_pend = pend;
		next_rep = '0;
		if (cmd.valid) begin
			// writes wait in the pending copy [R14]
			if (!cmd.query && !is_apply_cmd) begin
				next_pending[sel] = cmd.value;
				next_pend[sel] = 1'b1;
			end
			// apply option or apply command releases all pending [R14] [R22]
			if (apply) begin
				for (int i = 0; i < NPARAM; i++) begin
					if (next_pend[i]) begin
						next_active[i] = next_pending[i];
						next_pend[i] = 1'b0;
					end
				end
			end
			// answer at once, even for broadcasts [R19]
			next_rep.valid = 1'b1;
			next_rep.frame_id = cmd.frame_id; // [R17]
			next_rep.value = cmd.query ? active[sel] : 16'h0000; // [R16]
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			active <= '{default: 16'h0000};
			pending <= '{default: 16'h0000};
			pend <= '0;
			rep <= '0;
		end else begin
			active <= next_active;
			pending <= next_pending;
			pend <= next_pend;
			rep <= next_rep;
		end
	end

	chk_reply_now: assert property (@(posedge core_clk) disable iff (reset)
		cmd.valid |=> rep.valid && rep.frame_id == $past(cmd.frame_id)) // [R19]
		else $error("remote command reply missing or wrong id");
	chk_write_held: assert property (@(posedge core_clk) disable iff (reset)
		cmd.valid && !cmd.query && !apply |=> active[$past(sel)] == $past(active[sel])) // [R14]
		else $error("write took effect without apply");
endmodule
`default_nettype wire

/* File: rac_host_model.sv */
// host side model: builds api frames and streams them byte by byte
`timescale 1ns/1ps
`default_nettype none
module rac_host_model import rac_pkg::*; (
	output logic [7:0] host_byte,
	output logic host_valid,
	output logic host_last,
	input wire logic core_clk
);
	initial begin
		host_byte = 8'h00;
		host_valid = 1'b0;
		host_last = 1'b0;
	end
	// bad flips one checksum bit so the frame has to be dropped
	task automatic emit(input logic [7:0] f[$], input bit bad);
		logic [7:0] s;
		s = 8'h00;
		foreach (f[i]) s = s + f[i];
		f.push_back((8'hff - s) ^ {7'h00, bad});
		foreach (f[i]) begin
			@(posedge core_clk);
			host_byte <= f[i];
			host_valid <= 1'b1;
			host_last <= (i == f.size() - 1);
		end
		@(posedge core_clk);
		host_valid <= 1'b0;
		host_last <= 1'b0;
		// released line must not keep showing the checksum
		host_byte <= ~f[f.size() - 1];
	endtask
	// fixed unicast destination, never the broadcast address
	task automatic head(inout logic [7:0] f[$], input logic [7:0] t, input logic [7:0] id);
		f = {t, id};
		repeat (8) f.push_back(8'h5a);
		f.push_back(8'hff);
		f.push_back(8'hfe);
	endtask
	task automatic send_tx(input logic [7:0] id, input logic [15:0] clu, input logic [7:0] opt,
			input bit bad);
		logic [7:0] f[$];
		head(f, FT_TX_EXPL, id);
		f = {f, 8'he8, 8'he8, clu[15:8], clu[7:0], 8'h12, 8'h34, 8'h00, opt & 8'hcf};
		f = {f, 8'h54, 8'h78};
		emit(f, bad);
	endtask
	task automatic send_rc(input logic [7:0] id, input logic [7:0] opt, input logic [15:0] cmd,
			input bit query, input logic [15:0] val, input bit bad);
		logic [7:0] f[$];
		head(f, FT_RCMD, id);
		f = {f, opt & 8'h03, cmd[15:8], cmd[7:0]};
		if (!query) begin
			f.push_back(val[15:8]);
			f.push_back(val[7:0]);
		end
		emit(f, bad);
	endtask
endmodule
`default_nettype wire

/* File: rac_api_block_tb.sv */
// self-checking testbench of the api frame block
`timescale 1ns/1ps
`default_nettype none
module rac_api_block_tb import rac_pkg::*; ;
	logic core_clk, reset, host_valid, host_last, reg_wr, reg_rd, tx_done, tx_ok, loop_echo;
	logic [7:0] host_byte, reg_wdata, reg_rdata;
	logic [3:0] reg_addr;
	rac_tx_t tx_req;
	rac_netrx_t net_rx;
	rac_rcmd_t rcmd_out, rcmd_in;
	rac_rrep_t rrep_in, rrep_out;
	rac_resp_t resp;
	int error_cnt, num_checks;

	rac_host_model i_rac_host_model (.core_clk, .host_byte, .host_valid, .host_last);
	rac_api_block #(.NPARAM(8)) i_rac_api_block (.core_clk, .reset, .host_byte, .host_valid,
		.host_last, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_done, .tx_ok,
		.tx_req, .net_rx, .loop_echo, .rcmd_out, .rrep_in, .rcmd_in, .rrep_out, .resp);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	function automatic logic sel(int w);
		case (w)
			0: return tx_req.valid;
			1: return rcmd_out.valid;
			2: return resp.valid;
			default: return loop_echo;
		endcase
	endfunction
	// bounded watch; a missing pulse ends the run
	task automatic await(input int w, input bit want, input string m);
		bit got;
		got = 1'b0;
		#1;
		for (int i = 0; i < 8 && !got; i++) begin
			if (sel(w) === 1'b1) got = 1'b1;
			else begin
				@(posedge core_clk);
				#1;
			end
		end
		check(got == want, m);
		if (want && !got) print_verdict;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// released payload fields flip so stale values cannot pass
	task automatic pulse(input int w, input logic [7:0] id, input logic [15:0] v, input logic b);
		@(posedge core_clk);
		if (w == 0) {tx_done, tx_ok} <= {1'b1, b};
		else if (w == 1) rrep_in <= rac_rrep_t'{1'b1, id, v};
		else net_rx <= rac_netrx_t'{1'b1, v, b};
		@(posedge core_clk);
		if (w == 0) {tx_done, tx_ok} <= {1'b0, ~b};
		else if (w == 1) rrep_in <= rac_rrep_t'{1'b0, ~id, ~v};
		else net_rx <= rac_netrx_t'{1'b0, ~v, ~b};
	endtask

	task automatic t_regs;
		logic [7:0] d;
		reg_read(REG_DEF_TXO, d);
		check(d === DEF_TXO_RST, "default options reset");
		reg_read(REG_DELIVERY, d);
		check(d === DELIVERY_RST, "delivery reset");
		reg_read(REG_API_FMT, d);
		check(d === API_FMT_RST, "format reset");
		reg_write(4'h2, 8'h5a);
		reg_read(4'h2, d);
		check(d === 8'h00, "unmapped read");
		reg_write(REG_STATUS, 8'hff);
		reg_read(REG_STATUS, d);
		check(d === 8'h00, "status is read-only");
		reg_write(REG_DEF_TXO, 8'h4f);
		reg_read(REG_DEF_TXO, d);
		check(d === 8'h4f, "default options readback");
	endtask
	// rows: delivery, default options, request options
	task automatic t_opts;
		logic [23:0] rows [8];
		logic [7:0] o;
		logic [1:0] m;
		rac_tx_t e;
		rows = '{24'h00004f, 24'h000080, 24'h0000c2, 24'h008100, 24'h01000e, 24'h0100c9,
			24'h01000f, 24'h01004e};
		for (int k = 0; k < 8; k++) begin
			reg_write(REG_DELIVERY, rows[k][23:16]);
			reg_write(REG_DEF_TXO, rows[k][15:8]);
			i_rac_host_model.send_tx(8'h00, (k == 6) ? 16'h0012 : 16'h0011, rows[k][7:0], 1'b0);
			o = (rows[k][7:0] == 8'h00) ? rows[k][15:8] : rows[k][7:0];
			m = o[7:6];
			if (m == 2'b00) m = (rows[k][23:16] == 8'h00) ? 2'b01 : 2'b11;
			if (m == 2'b11 && rows[k][23:16] == 8'h00) m = 2'b01;
			e = rac_tx_t'{1'b1, 8'h00, o[0], o[1] & (m == 2'b11), o[2] & (m == 2'b11),
				o[3] & (m == 2'b11), rac_method_t'(m), k == 6};
			await(0, 1'b1, "transmit request missing");
			check(tx_req === e, "transmit fields");
			pulse(0, 8'h00, 16'h0000, 1'b0);
			await(2, 1'b0, "response to frame id zero");
		end
	endtask
	task automatic t_status;
		logic [7:0] opts [3];
		opts = '{8'h04, 8'h08, 8'h00};
		reg_write(REG_DELIVERY, 8'h01);
		reg_write(REG_DEF_TXO, 8'h00);
		for (int k = 0; k < 3; k++) begin
			i_rac_host_model.send_tx(8'h50 + k[7:0], 16'h0011, opts[k], 1'b0);
			await(0, 1'b1, "transmit request missing");
			pulse(0, 8'h00, 16'h0000, k != 0);
			await(2, 1'b1, "status frame missing");
			check(resp.frame_type === FT_TX_STAT && resp.frame_id === 8'h50 + k[7:0]
				&& resp.status[0] === (k == 0), "status frame");
			@(posedge core_clk);
			#1;
			check((k == 2) ? resp.valid === 1'b0 : (resp.valid === 1'b1 && resp.frame_type
				=== FT_ROUTE && resp.status[0] === (k == 1)), "route frame");
		end
	endtask
	task automatic t_badsum;
		logic [7:0] d0, d1;
		reg_read(REG_STATUS, d0);
		i_rac_host_model.send_tx(8'h61, 16'h0011, 8'h41, 1'b1);
		await(0, 1'b0, "request from bad frame");
		i_rac_host_model.send_rc(8'h62, 8'h00, 16'h4e49, 1'b1, 16'h0000, 1'b1);
		await(1, 1'b0, "command from bad frame");
		reg_read(REG_STATUS, d1);
		check(d1[7:4] === d0[7:4] + 4'h2, "bad frame count");
	endtask
	task automatic t_rcmd;
		i_rac_host_model.send_rc(8'h27, 8'h02, 16'h4e49, 1'b0, 16'h5265, 1'b0);
		await(1, 1'b1, "remote command missing");
		check(rcmd_out === rac_rcmd_t'{1'b1, 8'h27, 16'h4e49, 1'b0, 1'b1, 16'h5265}, "write");
		i_rac_host_model.send_rc(8'hfa, 8'h00, 16'h5450, 1'b1, 16'h0000, 1'b0);
		await(1, 1'b1, "remote query missing");
		check(rcmd_out.query === 1'b1 && rcmd_out.apply === 1'b0, "query");
		pulse(1, 8'hfa, 16'h0123, 1'b0);
		await(2, 1'b1, "remote response missing");
		check(resp === rac_resp_t'{1'b1, FT_RCMD_RESP, 8'hfa, 16'h0123}, "response");
		pulse(1, 8'h00, 16'h0456, 1'b0);
		await(2, 1'b0, "response to frame id zero");
	endtask
	task automatic rnode(input logic [7:0] id, input logic [15:0] cmd, input logic q,
			input logic ap, input logic [15:0] v, input logic [15:0] ex);
		@(posedge core_clk);
		rcmd_in <= rac_rcmd_t'{1'b1, id, cmd, q, ap, v};
		@(posedge core_clk);
		rcmd_in <= rac_rcmd_t'{1'b0, ~id, ~cmd, ~q, ~ap, ~v};
		#1;
		check(rrep_out === rac_rrep_t'{1'b1, id, ex}, "node reply");
	endtask
	task automatic t_rnode;
		rnode(8'h31, 16'h4e49, 1'b0, 1'b1, 16'h1111, 16'h0000);
		rnode(8'h32, 16'h4e49, 1'b1, 1'b0, 16'h0000, 16'h1111);
		rnode(8'h33, 16'h4e49, 1'b0, 1'b0, 16'h1234, 16'h0000);
		rnode(8'h34, 16'h4e49, 1'b1, 1'b0, 16'h0000, 16'h1111);
		rnode(8'h35, APPLY_CMD, 1'b0, 1'b0, 16'h0000, 16'h0000);
		rnode(8'h36, 16'h4e49, 1'b1, 1'b0, 16'h0000, 16'h1234);
	endtask
	task automatic t_loop;
		pulse(2, 8'h00, 16'h0012, 1'b0);
		await(3, 1'b1, "loopback echo missing");
		await(2, 1'b0, "receive frame at destination");
		for (int k = 0; k < 2; k++) begin
			reg_write(REG_API_FMT, k[7:0]);
			pulse(2, 8'h00, 16'h0012, 1'b1);
			await(2, 1'b1, "receive frame missing");
			check(resp.frame_type === (k == 0 ? FT_RX_NATIVE : FT_RX_EXPL), "rx type");
		end
	endtask

	initial begin
		error_cnt = 0;
		num_checks = 0;
		reset = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, tx_done, tx_ok} = '0;
		net_rx = '0;
		rrep_in = '0;
		rcmd_in = '0;
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		t_regs;
		t_opts;
		t_status;
		t_badsum;
		t_rcmd;
		t_rnode;
		t_loop;
		print_verdict;
	end
endmodule
`default_nettype wire
